// ---- bench/ecs_periph_model.sv ----
// Behavioural EPP peripheral on the cable side
`timescale 1ns/100ps
module ecs_periph_model (
   // Clock and reset
   input  logic       clk,
   input  logic       reset_n,
   // Cable
   input  logic       data_strobe_n,
   input  logic       address_strobe_n,
   input  logic       write_line_n,
   input  logic       cable_data_oe,
   input  logic [7:0] cable_data_out,
   output logic       peripheral_wait_n,
   output logic [7:0] cable_data_in,
   // Bench controls
   input  logic [7:0] rd_byte,
   input  logic [3:0] delay,
   input  logic       stuck,
   input  logic       hold_hi,
   output logic [7:0] got_byte
);
   logic       wait_q, drv, strb;
   logic [3:0] cnt;
   logic [7:0] last;

   assign strb              = !data_strobe_n || !address_strobe_n;
   assign peripheral_wait_n = wait_q || hold_hi;
   // Undriven bus toggles each cycle
   assign cable_data_in     = cable_data_oe ? cable_data_out : drv ? rd_byte : ~last;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {wait_q, drv, cnt, last, got_byte} <= '0;
      end else begin
         last <= cable_data_in;
         if (strb) begin
            cnt <= (cnt == 4'hf) ? cnt : cnt + 4'h1;
            if (!write_line_n) got_byte <= cable_data_in;
            if (write_line_n && !stuck) drv <= 1'b1;
            if (cnt >= delay && !stuck) wait_q <= 1'b1;
         end else begin
            cnt <= 4'h0;
            if (drv) drv <= 1'b0;
            else wait_q <= 1'b0;
         end
      end
   end
endmodule : ecs_periph_model

// ---- bench/ecs_seq_chk.sv ----
// Port assertions for the EPP cycle sequencer
`timescale 1ns/100ps
module ecs_seq_chk (
   // Clock, reset and host side
   input logic        clk,
   input logic        reset_n,
   input logic        avs_read,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   // Cable side
   input logic [7:0]  cable_data_in,
   input logic [7:0]  cable_data_out,
   input logic        cable_data_oe,
   input logic        cable_direction_out,
   input logic        write_line_n,
   input logic        data_strobe_n,
   input logic        address_strobe_n,
   input logic        peripheral_wait_n,
   input logic        peripheral_interrupt_in,
   input logic        interrupt_out
);
   logic        any_low, rd_done;
   logic [11:0] strb_cnt, next_strb_cnt;

   assign any_low = !data_strobe_n || !address_strobe_n;
   assign rd_done = any_low && write_line_n && peripheral_wait_n && avs_read;

   // ----------------------------------------
   // Strobe length counter
   // ----------------------------------------
   always_comb next_strb_cnt = !any_low ? 12'h000 : strb_cnt + 12'(strb_cnt != 12'hfff);
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) strb_cnt <= 12'h000;
      else strb_cnt <= next_strb_cnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_write_setup: assert property (
      $rose(any_low) && !write_line_n |-> cable_data_oe && !cable_direction_out)
      else $error("Write strobe without bus drive");
   a_read_setup: assert property (
      $rose(any_low) && write_line_n |-> !cable_data_oe && cable_direction_out)
      else $error("Read strobe with bus driven");
   a_strobe_hold: assert property (
      any_low && !peripheral_wait_n |=> any_low || !avs_waitrequest)
      else $error("Strobe dropped while wait low");
   a_ready_cause: assert property (
      !avs_waitrequest && $past(any_low) |-> $past(peripheral_wait_n) || $past(strb_cnt) > 12'd1900)
      else $error("Host released before wait high");
   a_answer_pulse: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("Waitrequest low over one cycle");
   a_read_capture: assert property (
      !avs_waitrequest && $past(rd_done) |-> avs_readdata[7:0] == $past(cable_data_in))
      else $error("Read byte not from cable");
   a_upper_zero: assert property (
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("Upper read bits not zero");
   a_write_stable: assert property (
      any_low && $past(any_low) && !write_line_n |-> $stable(cable_data_out) && cable_data_oe)
      else $error("Write byte moved under strobe");
   a_pins_stable: assert property (
      any_low && $past(any_low) |-> $stable(cable_direction_out) && $stable(write_line_n))
      else $error("Direction changed under strobe");
   a_irq_pass: assert property (
      1'b1 |=> interrupt_out == $past(peripheral_interrupt_in))
      else $error("Interrupt not passed through");

   c_write: cover property ($rose(any_low) && !write_line_n);
   c_read: cover property (!avs_waitrequest && $past(rd_done));
   c_abort: cover property (!avs_waitrequest && $past(strb_cnt) > 12'd1900);
endmodule : ecs_seq_chk

bind ecs_cycle_sequencer ecs_seq_chk chk_u (
   .clk(clk), .reset_n(reset_n), .avs_read(avs_read), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .cable_data_in(cable_data_in),
   .cable_data_out(cable_data_out), .cable_data_oe(cable_data_oe),
   .cable_direction_out(cable_direction_out), .write_line_n(write_line_n),
   .data_strobe_n(data_strobe_n), .address_strobe_n(address_strobe_n),
   .peripheral_wait_n(peripheral_wait_n), .interrupt_out(interrupt_out),
   .peripheral_interrupt_in(peripheral_interrupt_in));

// ---- bench/tb_top.sv ----
// Self-checking bench for the EPP cycle sequencer
`timescale 1ns/100ps
module tb_top;
   logic        clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [5:0]  avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic        avs_waitrequest, cable_data_oe, cable_direction_out, write_line_n, init_n;
   logic        data_strobe_n, address_strobe_n, peripheral_wait_n, interrupt_out;
   logic [7:0]  cable_data_in, cable_data_out, got_byte, rd, wd, ctl;
   logic [7:0]  rd_byte = 8'h00;
   logic [3:0]  delay = 4'h2, idx;
   logic        stuck = 1'b0, hold_hi = 1'b0, peripheral_interrupt_in = 1'b0;
   logic        irq_q, saw_addr, saw_data, saw_wr;
   integer      seed = 32'h32e98a77;
   int          failures = 0, check_count = 0, cyc = 0;

   ecs_cycle_sequencer dut_u (
      .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cable_data_in(cable_data_in), .cable_data_out(cable_data_out),
      .cable_data_oe(cable_data_oe), .cable_direction_out(cable_direction_out),
      .write_line_n(write_line_n), .data_strobe_n(data_strobe_n),
      .address_strobe_n(address_strobe_n), .init_n(init_n),
      .peripheral_wait_n(peripheral_wait_n),
      .peripheral_interrupt_in(peripheral_interrupt_in), .interrupt_out(interrupt_out));
   ecs_periph_model peer_u (
      .clk(clk), .reset_n(reset_n), .data_strobe_n(data_strobe_n),
      .address_strobe_n(address_strobe_n), .write_line_n(write_line_n),
      .cable_data_oe(cable_data_oe), .cable_data_out(cable_data_out),
      .peripheral_wait_n(peripheral_wait_n), .cable_data_in(cable_data_in),
      .rd_byte(rd_byte), .delay(delay), .stuck(stuck), .hold_hi(hold_hi),
      .got_byte(got_byte));

   always #2.5 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      irq_q <= peripheral_interrupt_in;
      peripheral_interrupt_in <= 1'($random(seed));
      if (!address_strobe_n) saw_addr <= 1'b1;
      if (!data_strobe_n) saw_data <= 1'b1;
      if ((!data_strobe_n || !address_strobe_n) && !write_line_n) saw_wr <= 1'b1;
      if (cyc == 20000) begin
         failures++;
         final_report();
      end
   end

   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic bus_op(input logic wr, input logic [3:0] ix, input logic [7:0] d);
      @(posedge clk);
      avs_address <= {ix, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, d};
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus_op

   task automatic cable_op(input logic wr, input logic [3:0] ix, input logic [7:0] d,
                           input logic chk);
      {saw_addr, saw_data, saw_wr} <= 3'b000;
      bus_op(wr, ix, d);
      repeat (3) @(posedge clk);
      check("addr_strobe", 8'(saw_addr), 8'(ix == 4'h3));
      check("data_strobe", 8'(saw_data), 8'(ix != 4'h3));
      if (chk && wr) check("wr_byte", got_byte, d);
      else if (chk) check("rd_byte", rd, rd_byte);
   endtask : cable_op

   function automatic logic exp_wline(input logic m19, input logic [7:0] c);
      return m19 ? !c[0] : c[5];
   endfunction : exp_wline

   task automatic final_report();
      if (failures == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         bus_op(1'b0, (i < 3) ? 4'(i) : 4'h8 + 4'(i[0]), 8'h00);
         check("reg_reset", rd, 8'(i >= 3 && !i[0]));
      end
      bus_op(1'b1, 4'h2, 8'h05);
      @(posedge clk);
      @(negedge clk);
      check("wline_ctrl", 8'(write_line_n), 8'(exp_wline(1'b1, 8'h05)));
      check("init_ctrl", 8'(init_n), 8'h01);
      cable_op(1'b0, 4'h4, 8'h00, 1'b0);
      check("forced_write", 8'(saw_wr), 8'h01);
      bus_op(1'b1, 4'h2, 8'h00);
      hold_hi <= 1'b1;
      fork
         cable_op(1'b1, 4'h4, 8'h5a, 1'b1);
         begin
            repeat (20) @(posedge clk);
            check("hold_strobe", 8'(data_strobe_n && write_line_n), 8'h01);
            check("hold_ready", 8'(avs_waitrequest), 8'h01);
            hold_hi <= 1'b0;
         end
      join
      bus_op(1'b1, 4'h2, 8'h20);
      cable_op(1'b1, 4'h4, 8'ha5, 1'b0);
      check("dir_write", got_byte, 8'h5a);
      for (int m = 1; m >= 0; m--) begin
         bus_op(1'b1, 4'h8, 8'(m));
         for (int i = 0; i < 12; i++) begin
            ctl = (m == 0 && !i[0]) ? 8'h20 : 8'h00;
            bus_op(1'b1, 4'h2, ctl);
            @(posedge clk);
            @(negedge clk);
            check("wline_idle", 8'(write_line_n), 8'(exp_wline(m[0], ctl)));
            check("oe_idle", 8'(cable_data_oe), 8'(!ctl[5]));
            check("dir_idle", 8'(cable_direction_out), 8'(ctl[5]));
            idx = 4'h3 + 4'($unsigned($random(seed)) % 5);
            rd_byte <= 8'($random(seed));
            delay <= 4'h2 + 4'($unsigned($random(seed)) % 8);
            cable_op(i[0], idx, 8'($random(seed)), 1'b1);
         end
      end
      stuck <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         bus_op(1'b1, 4'h8, 8'(m));
         cable_op(1'b1, 4'h4, 8'h3c, 1'b0);
         bus_op(1'b0, 4'h1, 8'h00);
         check("tmo_set", rd & 8'h01, 8'h01);
         bus_op(1'b1, 4'h1, 8'h00);
         bus_op(1'b0, 4'h1, 8'h00);
         check("tmo_keep", rd & 8'h01, 8'h01);
         bus_op(1'b1, 4'h1, 8'h01);
         bus_op(1'b0, 4'h1, 8'h00);
         check("tmo_clear", rd & 8'h01, 8'h00);
      end
      stuck <= 1'b0;
      @(negedge clk);
      check("irq_pass", 8'(interrupt_out), 8'(irq_q));
      final_report();
   end
endmodule : tb_top

// ---- logic/ecs_ctl_if.sv ----
// Links between sequencer, register file and watchdog
`timescale 1ns/100ps
interface ecs_ctl_if;
   import ecs_pkg::*;

   logic       wr_en;
   logic [3:0] wr_index;
   ecs_byte_t  wr_data;
   logic       set_timeout;
   ecs_byte_t  ctrl;
   ecs_byte_t  spp_data;
   ecs_byte_t  mode;
   logic       timeout_status;
   logic       wd_run;
   logic       wd_expired;

   modport seq (
      output wr_en, wr_index, wr_data, set_timeout, wd_run,
      input  ctrl, spp_data, mode, timeout_status, wd_expired
   );
   modport regs (
      input  wr_en, wr_index, wr_data, set_timeout,
      output ctrl, spp_data, mode, timeout_status
   );
   modport wdog (
      input  wd_run,
      output wd_expired
   );
endinterface : ecs_ctl_if

// ---- logic/ecs_cycle_sequencer.sv ----
// EPP cycle sequencer with Avalon-MM register slave
//
// Functional notes
// - 1.9: hold host wait at cycle start until completion is certain.
// - 1.9: if wait line idle high, wait for it low before acting.
// - 1.9 write: drive byte, direction low, write line low, then strobe.
// - 1.9 write: after wait high, drop strobe, keep byte, release host.
// - 1.9 read: float bus, write line high, strobe with direction high.
// - 1.9 read: on wait high capture byte, drop strobe, return, release.
// - Outside cycles, pins follow control register and direction bit.
// - 1.7: over 10 us host strobe aborts cycle, sets timeout status.
// - 1.7: host held waiting only while wait line is low.
// - 1.7: direction bit high floats bus, releases write line; low asserts.
// - 1.7 write: drive byte, strobe; drop strobe at host release.
// - 1.7 read: strobe after host read starts, drop at host release.
// - Address strobe for address port, data strobe for data ports.
// - Direction output low for output, high only for input or reads.
// - Strobe bit overrides bus drive, direction and write line in cycle; 1.9 writes need direction low.
// - Interrupt input passed through uninverted, active high.
// - 1.9: over 10 us to wait release aborts cycle, sets timeout.
// - Timeout bit clears on reset or write of one.
// - Strobe control bit in a cycle forces write direction, write line.
`timescale 1ns/100ps
`include "ecs_regs.svh"
module ecs_cycle_sequencer
   import ecs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Cable data bus
   input  wire logic [7:0]  cable_data_in,
   output logic      [7:0]  cable_data_out,
   output logic             cable_data_oe,
   output logic             cable_direction_out,
   // Cable control and status
   output logic             write_line_n,
   output logic             data_strobe_n,
   output logic             address_strobe_n,
   output logic             init_n,
   input  wire logic        peripheral_wait_n,
   input  wire logic        peripheral_interrupt_in,
   output logic             interrupt_out
);

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   ecs_ctl_if ctl ();

   ecs_regfile u_regs (
      .clk     (clk),
      .reset_n (reset_n),
      .ctl     (ctl.regs)
   );

   ecs_watchdog u_wdog (
      .clk     (clk),
      .reset_n (reset_n),
      .ctl     (ctl.wdog)
   );

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   ecs_state_t state;
   ecs_state_t next_state;
   logic       cyc_read;
   logic       next_cyc_read;
   logic       cyc_addr;
   logic       next_cyc_addr;
   logic       cyc_epp;
   logic       next_cyc_epp;
   ecs_byte_t  out_byte;
   ecs_byte_t  next_out_byte;
   ecs_byte_t  rd_byte;
   ecs_byte_t  next_rd_byte;
   logic       timeout_hit;

   logic [3:0] req_index;
   logic       e19;
   logic       dir_ctl;

   assign req_index = avs_address[5:2];
   assign e19       = ctl.mode[`ECS_MODE_E19];
   assign dir_ctl   = ctl.ctrl[`ECS_CTRL_DIR];

   // Register writes land on the edge that completes the transfer
   assign ctl.wr_en       = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign ctl.wr_index    = req_index;
   assign ctl.wr_data     = avs_writedata[7:0];
   assign ctl.set_timeout = timeout_hit;
   assign ctl.wd_run      = (state == ST_HOLD19) || (state == ST_SET19) ||
                            (state == ST_STRB19) || (state == ST_STRB17);

   always_comb begin
      next_state    = state;
      next_cyc_read = cyc_read;
      next_cyc_addr = cyc_addr;
      next_cyc_epp  = cyc_epp;
      next_out_byte = out_byte;
      next_rd_byte  = rd_byte;
      timeout_hit   = 1'b0;
      unique case (state)
         ST_IDLE: begin
            next_cyc_epp = 1'b0;
            if (avs_read || avs_write) begin
               if (ecs_is_epp_port(req_index)) begin
                  next_cyc_epp  = 1'b1;
                  next_cyc_addr = (req_index == `ECS_IDX_EADDR);
                  next_out_byte = avs_writedata[7:0];
                  if (e19) begin
                     next_cyc_read = avs_read || dir_ctl;
                     next_state    = ST_HOLD19;
                  end else begin
                     next_cyc_read = avs_read;
                     next_state    = ST_STRB17;
                  end
               end else begin
                  next_state = ST_ACK;
               end
            end
         end
         ST_HOLD19: begin
            if (ctl.wd_expired) begin
               timeout_hit = 1'b1;
               next_state  = ST_ACK;
            end else if (!peripheral_wait_n) begin
               next_state = ST_SET19;
            end
         end
         ST_SET19: begin
            if (ctl.wd_expired) begin
               timeout_hit = 1'b1;
               next_state  = ST_ACK;
            end else begin
               next_state = ST_STRB19;
            end
         end
         ST_STRB19: begin
            if (ctl.wd_expired) begin
               timeout_hit = 1'b1;
               next_state  = ST_ACK;
            end else if (peripheral_wait_n) begin
               next_rd_byte = cable_data_in;
               next_state   = ST_ACK;
            end
         end
         ST_STRB17: begin
            if (ctl.wd_expired) begin
               timeout_hit = 1'b1;
               next_state  = ST_ACK;
            end else if (peripheral_wait_n) begin
               next_rd_byte = cable_data_in;
               next_state   = ST_ACK17;
            end
         end
         ST_ACK: begin
            next_state = ST_IDLE;
         end
         ST_ACK17: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state    <= ST_IDLE;
         cyc_read <= 1'b0;
         cyc_addr <= 1'b0;
         cyc_epp  <= 1'b0;
         out_byte <= 8'h00;
         rd_byte  <= 8'h00;
      end else begin
         state    <= next_state;
         cyc_read <= next_cyc_read;
         cyc_addr <= next_cyc_addr;
         cyc_epp  <= next_cyc_epp;
         out_byte <= next_out_byte;
         rd_byte  <= next_rd_byte;
      end
   end

   // ----------------------------------------
   // Pin and bus outputs
   // ----------------------------------------
   logic        next_waitrequest;
   logic [31:0] next_readdata;
   ecs_byte_t   next_data_out;
   logic        next_data_oe;
   logic        next_direction;
   logic        next_write_n;
   logic        next_dstb_n;
   logic        next_astb_n;
   logic        in_cycle;
   logic        strobe_on;
   logic        drive_out;

   always_comb begin
      in_cycle  = next_cyc_epp && (next_state != ST_IDLE) && (next_state != ST_HOLD19);
      strobe_on = (next_state == ST_STRB19) || (next_state == ST_STRB17) ||
                  (next_state == ST_ACK17);
      next_waitrequest = !((next_state == ST_ACK) || (next_state == ST_ACK17));
      next_readdata    = avs_readdata;
      if (!next_waitrequest) begin
         case (req_index)
            `ECS_IDX_DATA:   next_readdata = {24'h000000, dir_ctl ? cable_data_in : ctl.spp_data};
            `ECS_IDX_STATUS: next_readdata = {31'h00000000, ctl.timeout_status};
            `ECS_IDX_CTRL:   next_readdata = {26'h0000000, ctl.ctrl[5:0]};
            `ECS_IDX_MODE:   next_readdata = {24'h000000, ctl.mode};
            default: begin
               if (ecs_is_epp_port(req_index)) begin
                  next_readdata = {24'h000000, next_rd_byte};
               end else begin
                  next_readdata = 32'h00000000;
               end
            end
         endcase
      end
      if (in_cycle) begin
         // Strobe control bit forces write direction during a cycle
         if (e19) begin
            drive_out    = !cyc_read || ctl.ctrl[`ECS_CTRL_STROBE];
            next_write_n = !drive_out;
         end else begin
            drive_out    = !dir_ctl || ctl.ctrl[`ECS_CTRL_STROBE];
            next_write_n = !drive_out;
         end
         next_data_out  = next_out_byte;
         next_data_oe   = drive_out;
         next_direction = !drive_out;
         next_dstb_n    = !(strobe_on && !next_cyc_addr);
         next_astb_n    = !(strobe_on && next_cyc_addr);
      end else begin
         // Idle port follows control and data registers
         drive_out      = !dir_ctl;
         next_data_out  = ctl.spp_data;
         next_data_oe   = drive_out;
         next_direction = dir_ctl;
         if (e19) begin
            next_write_n = !ctl.ctrl[`ECS_CTRL_STROBE];
         end else begin
            // Cleared direction bit asserts the write line
            next_write_n = dir_ctl && !ctl.ctrl[`ECS_CTRL_STROBE];
         end
         next_dstb_n = !ctl.ctrl[`ECS_CTRL_AUTOFD];
         next_astb_n = !ctl.ctrl[`ECS_CTRL_SLCTIN];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata        <= 32'h00000000;
         avs_waitrequest     <= 1'b1;
         cable_data_out      <= 8'h00;
         cable_data_oe       <= 1'b1;
         cable_direction_out <= 1'b0;
         write_line_n        <= 1'b1;
         data_strobe_n       <= 1'b1;
         address_strobe_n    <= 1'b1;
         init_n              <= 1'b0;
         interrupt_out       <= 1'b0;
      end else begin
         avs_readdata        <= next_readdata;
         avs_waitrequest     <= next_waitrequest;
         cable_data_out      <= next_data_out;
         cable_data_oe       <= next_data_oe;
         cable_direction_out <= next_direction;
         write_line_n        <= next_write_n;
         data_strobe_n       <= next_dstb_n;
         address_strobe_n    <= next_astb_n;
         init_n              <= ctl.ctrl[`ECS_CTRL_INIT];
         interrupt_out       <= peripheral_interrupt_in;
      end
   end

endmodule : ecs_cycle_sequencer

// ---- logic/ecs_pkg.sv ----
// Types shared by the sequencer modules
package ecs_pkg;

   typedef logic [7:0] ecs_byte_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ACK,
      ST_HOLD19,
      ST_SET19,
      ST_STRB19,
      ST_STRB17,
      ST_ACK17
   } ecs_state_t;

   function automatic logic ecs_is_epp_port(input logic [3:0] idx);
      return (idx >= 4'h3) && (idx <= 4'h7);
   endfunction : ecs_is_epp_port

endpackage : ecs_pkg

// ---- logic/ecs_regfile.sv ----
// Software registers: port data, control, mode and timeout status
`timescale 1ns/100ps
`include "ecs_regs.svh"
module ecs_regfile
   import ecs_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Control link
   ecs_ctl_if.regs   ctl
);
   ecs_byte_t ctrl;
   ecs_byte_t spp_data;
   ecs_byte_t mode;
   logic      tmo;
   ecs_byte_t next_ctrl;
   ecs_byte_t next_spp_data;
   ecs_byte_t next_mode;
   logic      next_tmo;

   always_comb begin
      next_ctrl     = ctrl;
      next_spp_data = spp_data;
      next_mode     = mode;
      next_tmo      = tmo;
      if (ctl.wr_en) begin
         case (ctl.wr_index)
            `ECS_IDX_DATA:   next_spp_data = ctl.wr_data;
            `ECS_IDX_CTRL:   next_ctrl = {2'b00, ctl.wr_data[5:0]};
            `ECS_IDX_MODE:   next_mode = {7'h00, ctl.wr_data[`ECS_MODE_E19]};
            `ECS_IDX_STATUS: begin
               if (ctl.wr_data[`ECS_STAT_TIMEOUT]) begin
                  next_tmo = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Setting wins over a clear in the same cycle
      if (ctl.set_timeout) begin
         next_tmo = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl     <= `ECS_CTRL_RST;
         spp_data <= `ECS_DATA_RST;
         mode     <= `ECS_MODE_RST;
         tmo      <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         spp_data <= next_spp_data;
         mode     <= next_mode;
         tmo      <= next_tmo;
      end
   end

   assign ctl.ctrl           = ctrl;
   assign ctl.spp_data       = spp_data;
   assign ctl.mode           = mode;
   assign ctl.timeout_status = tmo;

endmodule : ecs_regfile

// ---- logic/ecs_regs.svh ----
// Register indices, field positions, reset values and timing counts
`ifndef ECS_REGS_SVH
`define ECS_REGS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define ECS_IDX_DATA    4'h0
`define ECS_IDX_STATUS  4'h1
`define ECS_IDX_CTRL    4'h2
`define ECS_IDX_EADDR   4'h3
`define ECS_IDX_EDATA0  4'h4
`define ECS_IDX_EDATA3  4'h7
`define ECS_IDX_MODE    4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ECS_CTRL_STROBE 0
`define ECS_CTRL_AUTOFD 1
`define ECS_CTRL_INIT   2
`define ECS_CTRL_SLCTIN 3
`define ECS_CTRL_DIR    5
`define ECS_STAT_TIMEOUT 0
`define ECS_MODE_E19    0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ECS_CTRL_RST    8'h00
`define ECS_DATA_RST    8'h00
`define ECS_MODE_RST    8'h01

// ----------------------------------------
// Timing
// ----------------------------------------
`define ECS_CLK_PERIOD_NS 5
`define ECS_TIMEOUT_NS    10000
`define ECS_WDOG_CYC ((`ECS_TIMEOUT_NS + `ECS_CLK_PERIOD_NS - 1) / `ECS_CLK_PERIOD_NS)

`endif

// ---- logic/ecs_watchdog.sv ----
// Cycle watchdog: flags an EPP cycle that runs too long
`timescale 1ns/100ps
`include "ecs_regs.svh"
module ecs_watchdog
   import ecs_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Control link
   ecs_ctl_if.wdog   ctl
);
   localparam logic [10:0] WD_LAST = 11'(`ECS_WDOG_CYC - 1);

   logic [10:0] count;
   logic [10:0] next_count;
   logic        expired;
   logic        next_expired;

   always_comb begin
      next_count   = 11'h000;
      next_expired = 1'b0;
      if (ctl.wd_run) begin
         next_expired = expired || (count >= WD_LAST);
         next_count   = (count >= WD_LAST) ? count : count + 11'h001;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count   <= 11'h000;
         expired <= 1'b0;
      end else begin
         count   <= next_count;
         expired <= next_expired;
      end
   end

   assign ctl.wd_expired = expired;

endmodule : ecs_watchdog
